// ### rtl/pstl_link.sv
// Device end of the one-byte polled telegram link with five-byte answers.
// Assumes the serial input is asynchronous and the line driver is
// enabled by ser_tx_oe; software feeds position and diagnostics.
//
// Overview of operation
// - 19.2 kbit/s, start, eight data, even parity, one stop, half duplex.
// - Two address bits pick one of four nodes; configured default is 0.
// - Byte with valid flag clear is ignored entirely.
// - Code 000 position, 001 diagnostics, 100 standby.
// - Several bits set: diagnostics first, then standby, then position.
// - Laser turns off after 10 s without a position request.
// - Position answer goes out about 30 ms after the request.
// - Diagnostic request returns diagnostics; error clears once queue empties.
// - Standby stops motor and laser; no diagnosis in standby.
// - Leaving standby needs about 5 s startup before normal work.
// - Answer is status, three data bytes, check byte.
// - Data bytes carry 21 bits, seven per byte, MSB first, bit 7 zero.
// - Check byte is XOR of answer bytes 0 to 3.
// - Status bit 0 shows an internal fault.
// - Status bit 1 shows tape code not decodable.
// - Status bit 2 marks diagnostic content in data bytes.
// - Status bit 3 set when answering position or diagnostics.
// - Status bits 5:4 node address, bit 6 standby, bit 7 zero.
// - Position answer: valid flag 1, diagnostic flag 0, standby 0.
// - Diagnostic answer: valid flag 1, diagnostic flag 1, standby 0.
// - Standby answer: valid and diagnostic flags 0, standby 1, data zero.
// - Diagnostics are three ASCII characters, codes E01 to E05, E09.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
module pstl_link #(
    parameter int unsigned BIT_CYCLES = pstl_pkg::BIT_CYC,
    parameter int unsigned RESP_DELAY_CYCLES = pstl_pkg::RESP_DELAY_CYC,
    parameter int unsigned LASER_OFF_CYCLES = pstl_pkg::LASER_OFF_CYC,
    parameter int unsigned STARTUP_CYCLES = pstl_pkg::STARTUP_CYC
) (
    input wire logic aclk, // 100 MHz clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [3:0] awaddr, // Write address
    input wire logic awvalid, // Write address valid
    output logic awready, // Write address ready
    input wire logic [31:0] wdata, // Write data
    input wire logic [3:0] wstrb, // Write byte enables
    input wire logic wvalid, // Write data valid
    output logic wready, // Write data ready
    output logic [1:0] bresp, // Write response
    output logic bvalid, // Write response valid
    input wire logic bready, // Write response ready
    input wire logic [3:0] araddr, // Read address
    input wire logic arvalid, // Read address valid
    output logic arready, // Read address ready
    output logic [31:0] rdata, // Read data
    output logic [1:0] rresp, // Read response
    output logic rvalid, // Read data valid
    input wire logic rready, // Read data ready
    input wire logic ser_rx, // Serial line receive
    output logic ser_tx, // Serial line transmit
    output logic ser_tx_oe, // Line driver enable
    output logic laser_on, // Laser enable
    output logic motor_on // Scanning motor enable
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_SEND = 3'b100
    } pstl_state_type;

    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    logic [31:0] aw_addr_ff, w_data_ff;
    logic [3:0] w_strb_ff;
    logic aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;
    logic [7:0] ctrl_ff;
    logic [20:0] pos_ff;
    logic [7:0] rx_err_cnt_ff;
    wire do_write = aw_got_ff && w_got_ff && !bvalid_ff;
    wire wr_ctrl = do_write && aw_addr_ff[3:0] == pstl_pkg::REG_CTRL;
    wire wr_pos = do_write && aw_addr_ff[3:0] == pstl_pkg::REG_POS;
    wire wr_diag = do_write && aw_addr_ff[3:0] == pstl_pkg::REG_DIAG;
    wire wr_ok = wr_ctrl || wr_pos || wr_diag;
    wire rd_take = arvalid && !rvalid_ff;
    assign awready = !aw_got_ff && !bvalid_ff;
    assign wready = !w_got_ff && !bvalid_ff;
    assign arready = !rvalid_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign rvalid = rvalid_ff;
    assign rresp = rresp_ff;
    assign rdata = rdata_ff;

    // Byte-lane merge of a write into an old value
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    wire [31:0] ctrl_new = merge({24'h000000, ctrl_ff}, w_data_ff, w_strb_ff);
    wire [31:0] pos_new = merge({11'h000, pos_ff}, w_data_ff, w_strb_ff);
    wire [1:0] node_addr = ctrl_ff[1:0];
    wire fault_in = ctrl_ff[2];
    wire tape_err = ctrl_ff[3];

    // Address and data may arrive in either order; response after both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= pstl_pkg::RESP_OKAY;
            aw_addr_ff <= 32'h00000000;
            w_data_ff <= 32'h00000000;
            w_strb_ff <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                aw_got_ff <= 1'b1;
                aw_addr_ff <= {28'h0000000, awaddr};
            end
            if (wvalid && wready) begin
                w_got_ff <= 1'b1;
                w_data_ff <= wdata;
                w_strb_ff <= wstrb;
            end
            if (do_write) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_ok ? pstl_pkg::RESP_OKAY : pstl_pkg::RESP_SLVERR;
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
            end else if (bvalid_ff && bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // Software-written configuration
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= pstl_pkg::CTRL_RESET;
            pos_ff <= 21'h000000;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= {4'h0, ctrl_new[3:0]};
            end
            if (wr_pos) begin
                pos_ff <= pos_new[20:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Diagnostic queue
    // ------------------------------------------------------------------
    logic [3:0] diag_mem_ff [4];
    logic [1:0] diag_wp_ff, diag_rp_ff;
    logic [2:0] diag_cnt_ff;
    logic err_ind_ff;
    logic diag_pop;
    wire diag_push = wr_diag && w_strb_ff[0] && diag_cnt_ff != pstl_pkg::DIAG_DEPTH;
    wire diag_empty = diag_cnt_ff == 3'h0;
    wire [3:0] diag_digit = diag_empty ? 4'h0 : diag_mem_ff[diag_rp_ff];

    // Error stays shown until the last stored entry is read; push wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            diag_wp_ff <= 2'h0;
            diag_rp_ff <= 2'h0;
            diag_cnt_ff <= 3'h0;
            err_ind_ff <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                diag_mem_ff[i] <= 4'h0;
            end
        end else begin
            if (diag_push) begin
                diag_mem_ff[diag_wp_ff] <= w_data_ff[3:0];
                diag_wp_ff <= diag_wp_ff + 2'h1;
            end
            if (diag_pop) begin
                diag_rp_ff <= diag_rp_ff + 2'h1;
            end
            diag_cnt_ff <= diag_cnt_ff + {2'h0, diag_push} - {2'h0, diag_pop};
            if (diag_push) begin
                err_ind_ff <= 1'b1;
            end else if (diag_pop && diag_cnt_ff == 3'h1) begin
                err_ind_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------------
    logic rx_s1_ff, rx_s2_ff, rx_busy_ff;
    logic [31:0] rx_cnt_ff;
    logic [3:0] rx_bit_ff;
    logic [9:0] rx_sh_ff;
    wire rx_tick = rx_busy_ff && rx_cnt_ff == 32'h00000000;
    wire rx_done = rx_tick && rx_bit_ff == pstl_pkg::FRAME_LAST;
    wire [7:0] rx_byte = rx_sh_ff[8:1];
    wire rx_par_ok = ~^rx_sh_ff[9:1];
    wire rx_good = rx_done && rx_par_ok && rx_s2_ff;
    wire rx_bad = rx_done && !(rx_par_ok && rx_s2_ff);

    // Sample mid-bit; a start bit that vanishes is taken as a glitch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_s1_ff <= 1'b1;
            rx_s2_ff <= 1'b1;
            rx_busy_ff <= 1'b0;
            rx_cnt_ff <= 32'h00000000;
            rx_bit_ff <= 4'h0;
            rx_sh_ff <= 10'h000;
            rx_err_cnt_ff <= 8'h00;
        end else begin
            rx_s1_ff <= ser_rx;
            rx_s2_ff <= rx_s1_ff;
            if (!rx_busy_ff) begin
                if (!rx_s2_ff) begin
                    rx_busy_ff <= 1'b1;
                    rx_cnt_ff <= 32'(BIT_CYCLES / 2);
                    rx_bit_ff <= 4'h0;
                end
            end else if (rx_tick) begin
                rx_cnt_ff <= 32'(BIT_CYCLES - 1);
                rx_bit_ff <= rx_bit_ff + 4'h1;
                rx_sh_ff <= {rx_s2_ff, rx_sh_ff[9:1]};
                if ((rx_bit_ff == 4'h0 && rx_s2_ff) || rx_done) begin
                    rx_busy_ff <= 1'b0;
                end
            end else begin
                rx_cnt_ff <= rx_cnt_ff - 32'h00000001;
            end
            if (rx_bad) begin
                rx_err_cnt_ff <= rx_err_cnt_ff + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------------
    // Request decode and operating mode
    // ------------------------------------------------------------------
    pstl_state_type state_ff;
    logic standby_ff, starting_ff, laser_idle_ff;
    logic [31:0] start_cnt_ff, laser_cnt_ff, wait_cnt_ff;
    wire req_ok = rx_good && rx_byte[pstl_pkg::REQ_VALID_BIT];
    wire addr_hit = rx_byte[pstl_pkg::REQ_ADDR_LO +: 2] == node_addr;
    wire accept = req_ok && addr_hit && state_ff == ST_IDLE;
    // Diagnostics outrank standby, standby outranks position
    wire req_diag = rx_byte[pstl_pkg::REQ_DIAG_BIT];
    wire req_stby = !req_diag && rx_byte[pstl_pkg::REQ_STANDBY_BIT];
    wire req_pos = !req_diag && !req_stby;
    wire asleep = standby_ff || starting_ff || req_stby;
    assign diag_pop = accept && req_diag && !asleep && !diag_empty;

    // Standby and startup; any non-standby request wakes the device
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            standby_ff <= 1'b0;
            starting_ff <= 1'b0;
            start_cnt_ff <= 32'h00000000;
        end else begin
            if (accept && req_stby) begin
                standby_ff <= 1'b1;
                starting_ff <= 1'b0;
            end else if (accept && standby_ff) begin
                standby_ff <= 1'b0;
                starting_ff <= 1'b1;
                start_cnt_ff <= 32'h00000000;
            end else if (starting_ff) begin
                start_cnt_ff <= start_cnt_ff + 32'h00000001;
                if (start_cnt_ff == 32'(STARTUP_CYCLES - 1)) begin
                    starting_ff <= 1'b0;
                end
            end
        end
    end

    // Laser idle timer restarts on every position request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            laser_cnt_ff <= 32'h00000000;
            laser_idle_ff <= 1'b0;
        end else if (accept && req_pos) begin
            laser_cnt_ff <= 32'h00000000;
            laser_idle_ff <= 1'b0;
        end else if (!laser_idle_ff) begin
            laser_cnt_ff <= laser_cnt_ff + 32'h00000001;
            if (laser_cnt_ff == 32'(LASER_OFF_CYCLES - 1)) begin
                laser_idle_ff <= 1'b1;
            end
        end
    end

    assign motor_on = !standby_ff;
    assign laser_on = !standby_ff && !laser_idle_ff;

    // ------------------------------------------------------------------
    // Answer assembly
    // ------------------------------------------------------------------
    logic [7:0] nxt_status;
    logic [20:0] nxt_data;
    always_comb begin
        nxt_status = 8'h00;
        nxt_status[pstl_pkg::ST_ERR] = err_ind_ff || fault_in;
        nxt_status[pstl_pkg::ST_OUT] = tape_err;
        nxt_status[pstl_pkg::ST_ADDR_LO +: 2] = node_addr;
        nxt_status[pstl_pkg::ST_SLEEP] = asleep;
        nxt_status[pstl_pkg::ST_RESPONSE_VALID_FLAG] = !asleep;
        nxt_status[pstl_pkg::ST_DB] = !asleep && req_diag;
        if (asleep) begin
            nxt_data = 21'h000000;
        end else if (req_diag) begin
            nxt_data = {pstl_pkg::CHAR_E, pstl_pkg::CHAR_ZERO,
                        pstl_pkg::CHAR_ZERO | {3'h0, diag_digit}};
        end else begin
            nxt_data = pos_ff;
        end
    end

    logic [7:0] resp_stat_ff;
    logic [20:0] resp_data_ff;
    logic [2:0] byte_idx_ff;
    logic [3:0] tx_bit_ff;
    logic [31:0] tx_cnt_ff;
    logic [10:0] tx_sh_ff;
    logic ser_tx_ff, oe_ff;
    // Seven data bits per byte, most significant group first
    wire [7:0] byte1 = {1'b0, resp_data_ff[20:14]};
    wire [7:0] byte2 = {1'b0, resp_data_ff[13:7]};
    wire [7:0] byte3 = {1'b0, resp_data_ff[6:0]};
    wire [7:0] chk = resp_stat_ff ^ byte1 ^ byte2 ^ byte3;
    wire [7:0] cur_byte = byte_idx_ff == 3'h0 ? resp_stat_ff :
                          byte_idx_ff == 3'h1 ? byte1 :
                          byte_idx_ff == 3'h2 ? byte2 :
                          byte_idx_ff == 3'h3 ? byte3 : chk;
    wire [10:0] frame = {1'b1, ^cur_byte, cur_byte, 1'b0};
    wire tx_tick = tx_cnt_ff == 32'h00000000;
    wire byte_end = tx_tick && tx_bit_ff == pstl_pkg::FRAME_LAST;
    wire all_sent = byte_idx_ff > pstl_pkg::RESP_LAST;
    assign ser_tx = ser_tx_ff;
    assign ser_tx_oe = oe_ff;

    // ------------------------------------------------------------------
    // Answer sequencer and transmitter
    // ------------------------------------------------------------------
    // Requests arriving while an answer is pending are dropped: the line
    // is half duplex, so the host must not talk over the answer.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= ST_IDLE;
            resp_stat_ff <= 8'h00;
            resp_data_ff <= 21'h000000;
            wait_cnt_ff <= 32'h00000000;
            byte_idx_ff <= 3'h0;
            tx_bit_ff <= 4'h0;
            tx_cnt_ff <= 32'h00000000;
            tx_sh_ff <= 11'h7FF;
            ser_tx_ff <= 1'b1;
            oe_ff <= 1'b0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (accept) begin
                        resp_stat_ff <= nxt_status;
                        resp_data_ff <= nxt_data;
                        wait_cnt_ff <= 32'h00000000;
                        byte_idx_ff <= 3'h0;
                        tx_bit_ff <= 4'h0;
                        tx_cnt_ff <= 32'h00000000;
                        // Only real position answers wait for a fresh value
                        state_ff <= (req_pos && !asleep) ? ST_WAIT : ST_SEND;
                    end
                end
                ST_WAIT: begin
                    wait_cnt_ff <= wait_cnt_ff + 32'h00000001;
                    if (wait_cnt_ff == 32'(RESP_DELAY_CYCLES - 1)) begin
                        resp_data_ff <= pos_ff;
                        state_ff <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    oe_ff <= 1'b1;
                    if (tx_bit_ff == 4'h0 && tx_tick && all_sent) begin
                        // Driver released only once the last stop bit has stood
                        oe_ff <= 1'b0;
                        state_ff <= ST_IDLE;
                    end else if (tx_bit_ff == 4'h0 && tx_tick) begin
                        ser_tx_ff <= frame[0];
                        tx_sh_ff <= {1'b1, frame[10:1]};
                        tx_bit_ff <= 4'h1;
                        tx_cnt_ff <= 32'(BIT_CYCLES - 1);
                    end else if (byte_end) begin
                        ser_tx_ff <= tx_sh_ff[0];
                        tx_sh_ff <= {1'b1, tx_sh_ff[10:1]};
                        tx_bit_ff <= 4'h0;
                        tx_cnt_ff <= 32'(BIT_CYCLES - 1);
                        byte_idx_ff <= byte_idx_ff + 3'h1;
                    end else if (tx_tick) begin
                        ser_tx_ff <= tx_sh_ff[0];
                        tx_sh_ff <= {1'b1, tx_sh_ff[10:1]};
                        tx_bit_ff <= tx_bit_ff + 4'h1;
                        tx_cnt_ff <= 32'(BIT_CYCLES - 1);
                    end else begin
                        tx_cnt_ff <= tx_cnt_ff - 32'h00000001;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Register read-back
    // ------------------------------------------------------------------
    wire [31:0] stat_word = {16'h0000, rx_err_cnt_ff, 3'h0, err_ind_ff,
                             motor_on, laser_on, starting_ff, standby_ff};
    wire [31:0] rd_val = araddr == pstl_pkg::REG_CTRL ? {24'h000000, ctrl_ff} :
                         araddr == pstl_pkg::REG_POS ? {11'h000, pos_ff} :
                         araddr == pstl_pkg::REG_DIAG ? {29'h00000000, diag_cnt_ff} :
                         araddr == pstl_pkg::REG_STAT ? stat_word : 32'h00000000;
    wire rd_hit = araddr == pstl_pkg::REG_CTRL || araddr == pstl_pkg::REG_POS ||
                  araddr == pstl_pkg::REG_DIAG || araddr == pstl_pkg::REG_STAT;

    // One read in flight; unmapped addresses answer with an error
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= pstl_pkg::RESP_OKAY;
        end else if (rd_take) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_val;
            rresp_ff <= rd_hit ? pstl_pkg::RESP_OKAY : pstl_pkg::RESP_SLVERR;
        end else if (rvalid_ff && rready) begin
            rvalid_ff <= 1'b0;
        end
    end
endmodule // pstl_link

// ### rtl/pstl_pkg.sv
// Constants for the position sensor telegram link.
// Assumes a 100 MHz aclk and an AXI4-Lite master for the register file.
package pstl_pkg;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_FREQ_HZ = 100_000_000;
    localparam int unsigned BAUD_BPS = 19_200;
    localparam int unsigned BIT_CYC = CLK_FREQ_HZ / BAUD_BPS;
    localparam int unsigned RESP_DELAY_MS = 30;
    localparam int unsigned RESP_DELAY_CYC = CLK_FREQ_HZ / 1000 * RESP_DELAY_MS;
    localparam int unsigned LASER_OFF_S = 10;
    localparam int unsigned LASER_OFF_CYC = CLK_FREQ_HZ * LASER_OFF_S;
    localparam int unsigned STARTUP_S = 5;
    localparam int unsigned STARTUP_CYC = CLK_FREQ_HZ * STARTUP_S;
    // ------------------------------------------------------------------
    // Character frame: start, 8 data, even parity, stop
    // ------------------------------------------------------------------
    localparam logic [3:0] FRAME_LAST = 4'hA;
    localparam logic [2:0] RESP_LAST = 3'h4;
    // ------------------------------------------------------------------
    // Request byte fields
    // ------------------------------------------------------------------
    localparam int REQ_VALID_BIT = 7;
    localparam int REQ_STANDBY_BIT = 6;
    localparam int REQ_DIAG_BIT = 4;
    localparam int REQ_ADDR_LO = 0;
    // ------------------------------------------------------------------
    // Status byte fields
    // ------------------------------------------------------------------
    localparam int ST_ERR = 0;
    localparam int ST_OUT = 1;
    localparam int ST_DB = 2;
    localparam int ST_RESPONSE_VALID_FLAG = 3;
    localparam int ST_ADDR_LO = 4;
    localparam int ST_SLEEP = 6;
    // Diagnostic characters
    localparam logic [6:0] CHAR_E = 7'h45;
    localparam logic [6:0] CHAR_ZERO = 7'h30;
    // ------------------------------------------------------------------
    // Register map (byte addresses) and bus answers
    // ------------------------------------------------------------------
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_POS = 4'h4;
    localparam logic [3:0] REG_DIAG = 4'h8;
    localparam logic [3:0] REG_STAT = 4'hC;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [2:0] DIAG_DEPTH = 3'h4;
    localparam logic [7:0] CTRL_RESET = 8'h00;
endpackage

// ### testbench/pstl_chk.sv
// Port checker for the telegram link.
// Assumes BIT_CYCLES of at least 8.
`timescale 1ns/1ns
module pstl_chk (
    input wire logic aclk, aresetn, arvalid, arready, rvalid, rready, bvalid, bready,
    input wire logic [31:0] rdata, // Read data
    input wire logic [1:0] bresp, // Write response
    input wire logic ser_tx, ser_tx_oe, laser_on, motor_on // Line and drives
);
    // Longest low run is start, eight zero data bits and zero parity at 16 clocks a bit, plus one bit of slack
    localparam int LOW_MAX = 176;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_idle; !ser_tx_oe |-> ser_tx; endproperty
    property p_start; $rose(ser_tx_oe) |-> !ser_tx [*8]; endproperty
    property p_stop; $fell(ser_tx_oe) |-> ser_tx; endproperty
    property p_dark; !motor_on |-> !laser_on; endproperty
    property p_rhold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
    property p_bhold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
    property p_rans; arvalid && arready |=> rvalid; endproperty
    property p_oe; ser_tx_oe && !ser_tx |-> ##[1:LOW_MAX] ser_tx; endproperty
    a_idle: assert property (p_idle) else $error("idle line low");
    a_start: assert property (p_start) else $error("short start bit");
    a_stop: assert property (p_stop) else $error("driver off mid bit");
    a_dark: assert property (p_dark) else $error("laser on in standby");
    a_rhold: assert property (p_rhold) else $error("read answer dropped");
    a_bhold: assert property (p_bhold) else $error("write answer dropped");
    a_rans: assert property (p_rans) else $error("no read answer");
    a_oe: assert property (p_oe) else $error("line stuck low");
    c_tx: cover property ($rose(ser_tx_oe));
    c_sb: cover property ($fell(motor_on));
    c_wr: cover property (bvalid && bready);
endmodule // pstl_chk
bind pstl_link pstl_chk chk_u (.*);

// ### testbench/pstl_host.sv
// Host side model: sends requests, collects five-byte answers.
// Line idles high; B is the bit length in clocks.
`timescale 1ns/1ns
module pstl_host #(parameter int B = 16) (
    input wire logic aclk, // Clock
    input wire logic ser_tx, // Device output
    input wire logic ser_tx_oe, // Device driver on
    output logic ser_rx // Request line
);
    initial ser_rx = 1'b1;
    // Gap first so a request never lands while an answer is still going out
    task automatic send(input logic [7:0] b, input logic bad);
        logic [10:0] f;
        f = {1'b1, ^b ^ bad, b, 1'b0};
        repeat (4 * B) @(posedge aclk);
        for (int i = 0; i < 11; i++) begin
            @(posedge aclk);
            ser_rx <= f[i];
            repeat (B - 1) @(posedge aclk);
        end
    endtask
    // ok stays low on silence or a bad parity bit
    task automatic get(output logic [7:0] r [5], output logic ok);
        int n;
        ok = 1'b0;
        for (int k = 0; k < 5; k++) begin
            n = 0;
            while (ser_tx_oe !== 1'b1 || ser_tx !== 1'b0) begin
                @(posedge aclk);
                if (++n > 400) return;
            end
            repeat (B / 2) @(posedge aclk);
            // Parity, then stop, before the next start bit is hunted
            for (int i = 0; i < 10; i++) begin
                repeat (B) @(posedge aclk);
                if (i < 8) r[k][i] = ser_tx;
                else if (ser_tx !== (i == 8 ? ^r[k] : 1'b1)) return;
            end
        end
        ok = 1'b1;
    endtask
endmodule // pstl_host

// ### testbench/pstl_link_tb_top.sv
// Self-checking bench for the telegram link.
// Uses shortened counts; host model stands on the serial line.
`timescale 1ns/1ns
module pstl_link_tb_top;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ser_rx, ser_tx, ser_tx_oe;
    logic laser_on, motor_on, awready, wready, bvalid, arready, rvalid, ok;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, rd;
    logic [1:0] bresp, rresp;
    logic [7:0] r [5];
    int n_fail, checked;
    pstl_link #(.BIT_CYCLES(16), .RESP_DELAY_CYCLES(20), .LASER_OFF_CYCLES(2000),
        .STARTUP_CYCLES(500)) dut_u (.*);
    pstl_host #(.B(16)) host_u (.aclk(aclk), .ser_tx(ser_tx), .ser_tx_oe(ser_tx_oe),
        .ser_rx(ser_rx));
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic test_done();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // One AXI4-Lite write (w=1) or read (w=0); each channel drops on its own edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a; araddr <= a; wdata <= d; wstrb <= 4'hF;
        awvalid <= w; wvalid <= w; bready <= w; arvalid <= !w; rready <= !w;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (arvalid && arready) arvalid <= 1'b0;
            if (bvalid && bready) bready <= 1'b0;
            if (rvalid && rready) begin rready <= 1'b0; rd = rdata; end
            if (++n > 50) begin n_fail++; test_done(); end
        end while (awvalid || wvalid || bready || arvalid || rready);
    endtask
    task automatic frame(input logic [7:0] q, input logic [7:0] st, input logic [20:0] d);
        host_u.send(q, 1'b0);
        host_u.get(r, ok);
        cmp("answer", 32'h1, {31'h0, ok});
        cmp("status", {24'h0, st}, {24'h0, r[0]});
        cmp("data", {1'b0, d[20:14], 1'b0, d[13:7], 1'b0, d[6:0]}, {r[1], r[2], r[3]});
        cmp("check", st ^ d[20:14] ^ d[13:7] ^ d[6:0], r[4]);
    endtask
    task automatic t_quiet(input logic [7:0] q, input logic bad);
        host_u.send(q, bad);
        host_u.get(r, ok);
        cmp("silent", 32'h0, {31'h0, ok});
    endtask
    task automatic t_pos();
        bus(1'b1, 4'h0, 32'h1);
        bus(1'b0, 4'h0, 32'h0);
        cmp("ctrl", 32'h1, rd);
        bus(1'b1, 4'h4, 32'h1ABCDE);
        frame(8'h81, 8'h18, 21'h1ABCDE);
        $display("position done");
    endtask
    task automatic t_diag();
        bus(1'b1, 4'h8, 32'h5);
        frame(8'hD1, 8'h1D, {pstl_pkg::CHAR_E, pstl_pkg::CHAR_ZERO, 7'h35});
        frame(8'h91, 8'h1C, {pstl_pkg::CHAR_E, pstl_pkg::CHAR_ZERO, 7'h30});
        $display("diagnostics done");
    endtask
    task automatic t_sleep();
        frame(8'hC1, 8'h50, 21'h0);
        cmp("motor", 32'h0, {31'h0, motor_on});
        frame(8'h81, 8'h50, 21'h0);
        repeat (600) @(posedge aclk);
        frame(8'h81, 8'h18, 21'h1ABCDE);
        repeat (2100) @(posedge aclk);
        cmp("laser", 32'h0, {31'h0, laser_on});
        $display("standby done");
    endtask
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
        aresetn = 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_pos();
        t_quiet(8'h82, 1'b0);
        t_quiet(8'h01, 1'b0);
        t_quiet(8'h81, 1'b1);
        t_diag();
        t_sleep();
        test_done();
    end
endmodule // pstl_link_tb_top
